// ==== design/bmu_unit.sv ====
// Purpose: single-bit instruction execution with register or memory operand
// Assumes: memory answers a read with mem_rdata in the same cycle that mem_rd is high
// Notes:   carry and zero flags held here; one request in flight at a time
//          timing of a register operand:
//            edge 0  request taken while idle and enabled
//            edge 0  write strobe, write byte, flags and done show
//          timing of a memory operand:
//            edge 0  request taken, op and index latched
//            edge 0  read strobe out, unit busy
//            edge 1  byte from memory used, flags updated
//            edge 1  write strobe and byte out for modifying ops
//            edge 2  done for modifying ops; non-modifying ones end at 1
//          the read strobe comes from a flop, so memory sees a clean
//          pulse; the price is one extra cycle of latency per access
//          requests seen while busy are dropped, not queued; the core
//          must hold off until busy falls
//          an external carry load in the same cycle as an op that
//          writes carry loses; the op result is the newer value
//          enable low freezes every flop, strobes included, so a strobe
//          stays up one cycle longer for each cycle enable is held low
//          the whole memory byte is written back, not just one bit;
//          memory with side effects on write sees a full byte write
//          inverted forms ignore the register index on purpose, since
//          their encodings carry an immediate index only
//          test and carry ops never raise a write strobe, so the
//          operand byte is left exactly as it was
//
// Contract
// - set writes 1 into chosen bit
// - clear writes 0 into chosen bit
// - invert complements the chosen bit
// - test loads zero flag with inverted bit
// - index from immediate or register low bits
// - carry becomes carry AND bit
// - carry becomes carry AND inverted bit
// - carry becomes carry OR bit
// - carry becomes carry OR inverted bit
// - carry becomes carry XOR bit
// - carry becomes carry XOR inverted bit
// - load copies bit into carry
// - inverted load copies inverted bit
// - store writes carry into chosen bit
// - inverted store writes inverted carry
// - inverted ops take immediate index only
`timescale 1ns/1ps
`include "bmu_params.svh"
module bmu_unit
    import bmu_pkg::*;
(
    // clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    // request
    input  wire logic                    req,
    input  wire bmu_op_t                 op,
    input  wire logic                    idx_from_reg,
    input  wire logic [`BMU_IDX_W-1:0]   idx_imm,
    input  wire logic [`BMU_DATA_W-1:0]  idx_reg,
    input  wire logic                    opnd_is_mem,
    input  wire logic [`BMU_DATA_W-1:0]  reg_opnd,
    output logic                         busy,
    // register write-back
    output logic                         reg_we,
    output logic [`BMU_DATA_W-1:0]       reg_wdata,
    // memory byte port
    output logic                         mem_rd,
    output logic                         mem_wr,
    output logic [`BMU_DATA_W-1:0]       mem_wdata,
    input  wire logic [`BMU_DATA_W-1:0]  mem_rdata,
    // flags
    input  wire logic                    c_load,
    input  wire logic                    c_load_val,
    output logic                         c_flag,
    output logic                         z_flag,
    output logic                         done
);
    bmu_state_t             st_r, st_nxt;        // sequencer
    bmu_op_t                op_r, op_nxt;        // latched op
    logic [`BMU_IDX_W-1:0]  idx_r, idx_nxt;      // latched index
    logic                   c_r, c_nxt;          // carry flag
    logic                   z_r, z_nxt;          // zero flag
    logic                   rwe_r, rwe_nxt;      // register write strobe
    logic [`BMU_DATA_W-1:0] rwd_r, rwd_nxt;      // register write data
    logic                   mrd_r, mrd_nxt;      // memory read strobe
    logic                   mwr_r, mwr_nxt;      // memory write strobe
    logic [`BMU_DATA_W-1:0] mwd_r, mwd_nxt;      // memory write data
    logic                   dn_r, dn_nxt;        // completion pulse
    logic                   inv_op;              // op allows immediate only
    logic [`BMU_IDX_W-1:0]  idx_sel;             // index chosen at request
    bmu_op_t                exe_op;              // op fed to datapath
    logic [`BMU_DATA_W-1:0] exe_byte;            // byte fed to datapath
    logic [`BMU_IDX_W-1:0]  exe_idx;             // index fed to datapath
    logic [`BMU_DATA_W-1:0] alu_res;
    logic                   alu_wr, alu_c, alu_cwr, alu_z, alu_zwr;

    // inverted carry-logic, load and store ignore the register index
    assign inv_op  = (op == BMU_CAND_INV) || (op == BMU_COR_INV) ||
                     (op == BMU_CXOR_INV) || (op == BMU_LOAD_INV) ||
                     (op == BMU_STORE_INV);
    assign idx_sel = (idx_from_reg && !inv_op) ? idx_reg[`BMU_IDX_W-1:0]
                                               : idx_imm;

    // register operands execute at once; memory uses latched request
    assign exe_op   = (st_r == BMU_RD) ? op_r : op;
    assign exe_idx  = (st_r == BMU_RD) ? idx_r : idx_sel;
    assign exe_byte = (st_r == BMU_RD) ? mem_rdata : reg_opnd;

    bmu_bitop u_bitop (
        .op    (exe_op),
        .opnd  (exe_byte),
        .idx   (exe_idx),
        .c_in  (c_r),
        .res   (alu_res),
        .wr_en (alu_wr),
        .c_out (alu_c),
        .c_wr  (alu_cwr),
        .z_out (alu_z),
        .z_wr  (alu_zwr)
    );

    // next-state logic for sequencer, flags and strobes
    always_comb begin
        st_nxt  = st_r;
        op_nxt  = op_r;
        idx_nxt = idx_r;
        c_nxt   = c_load ? c_load_val : c_r;
        z_nxt   = z_r;
        rwe_nxt = 1'b0;
        rwd_nxt = rwd_r;
        mrd_nxt = 1'b0;
        mwr_nxt = 1'b0;
        mwd_nxt = mwd_r;
        dn_nxt  = 1'b0;
        case (st_r)
            BMU_IDLE: begin
                if (req && opnd_is_mem) begin
                    // read byte first; bit update happens on return
                    op_nxt  = op;
                    idx_nxt = idx_sel;
                    mrd_nxt = 1'b1;
                    st_nxt  = BMU_RD;
                end else if (req) begin
                    if (alu_cwr) c_nxt = alu_c;
                    if (alu_zwr) z_nxt = alu_z;
                    rwe_nxt = alu_wr;
                    rwd_nxt = alu_res;
                    dn_nxt  = 1'b1;
                end
            end
            BMU_RD: begin
                // byte now on mem_rdata
                if (alu_cwr) c_nxt = alu_c;
                if (alu_zwr) z_nxt = alu_z;
                mwr_nxt = alu_wr;
                mwd_nxt = alu_res;
                st_nxt  = alu_wr ? BMU_WR : BMU_IDLE;
                dn_nxt  = !alu_wr;
            end
            BMU_WR: begin
                // write strobe is out this cycle
                st_nxt = BMU_IDLE;
                dn_nxt = 1'b1;
            end
            default: begin
                st_nxt = BMU_IDLE;
            end
        endcase
    end

    // registers; ce low freezes everything
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= BMU_IDLE;
            op_r  <= BMU_SET;
            idx_r <= '0;
            c_r   <= 1'b0;
            z_r   <= 1'b0;
            rwe_r <= 1'b0;
            rwd_r <= 8'h00;
            mrd_r <= 1'b0;
            mwr_r <= 1'b0;
            mwd_r <= 8'h00;
            dn_r  <= 1'b0;
        end else if (ce) begin
            st_r  <= st_nxt;
            op_r  <= op_nxt;
            idx_r <= idx_nxt;
            c_r   <= c_nxt;
            z_r   <= z_nxt;
            rwe_r <= rwe_nxt;
            rwd_r <= rwd_nxt;
            mrd_r <= mrd_nxt;
            mwr_r <= mwr_nxt;
            mwd_r <= mwd_nxt;
            dn_r  <= dn_nxt;
        end
    end

    assign busy      = (st_r != BMU_IDLE);
    assign reg_we    = rwe_r;
    assign reg_wdata = rwd_r;
    assign mem_rd    = mrd_r;
    assign mem_wr    = mwr_r;
    assign mem_wdata = mwd_r;
    assign c_flag    = c_r;
    assign z_flag    = z_r;
    assign done      = dn_r;
endmodule // bmu_unit

// ==== design/bmu_params.svh ====
// Purpose: constants for the single-bit manipulation unit
// Assumes: byte operands, 3-bit bit index
// Notes:   definitions only
`ifndef BMU_PARAMS_SVH
`define BMU_PARAMS_SVH
`define BMU_DATA_W   8
`define BMU_IDX_W    3
`define BMU_OP_W     4
`define BMU_MEM_LAT  1
`endif

// ==== design/bmu_pkg.sv ====
// Purpose: types for the single-bit manipulation unit
// Assumes: bmu_params.svh holds the numbers
// Notes:   operation codes are a plain enum
`include "bmu_params.svh"
package bmu_pkg;
    // operation select presented with each request
    typedef enum logic [`BMU_OP_W-1:0] {
        BMU_SET, BMU_CLEAR, BMU_INVERT, BMU_TEST,
        BMU_CAND, BMU_CAND_INV, BMU_COR, BMU_COR_INV,
        BMU_CXOR, BMU_CXOR_INV, BMU_LOAD, BMU_LOAD_INV,
        BMU_STORE, BMU_STORE_INV
    } bmu_op_t;
    // sequencer states
    typedef enum logic [1:0] {BMU_IDLE, BMU_RD, BMU_WR} bmu_state_t;
endpackage

// ==== design/bmu_bitop.sv ====
// Purpose: combinational single-bit operation on one byte and the flags
// Assumes: operand byte and index are stable while evaluated
// Notes:   pure logic, no state
`timescale 1ns/1ps
`include "bmu_params.svh"
module bmu_bitop
    import bmu_pkg::*;
(
    // request
    input  wire bmu_op_t                 op,
    input  wire logic [`BMU_DATA_W-1:0]  opnd,
    input  wire logic [`BMU_IDX_W-1:0]   idx,
    input  wire logic                    c_in,
    // result
    output logic [`BMU_DATA_W-1:0]       res,
    output logic                         wr_en,
    output logic                         c_out,
    output logic                         c_wr,
    output logic                         z_out,
    output logic                         z_wr
);
    logic [`BMU_DATA_W-1:0] sel_mask;   // one-hot for chosen bit
    logic                   bit_val;    // chosen operand bit

    // one-hot decode, one gate per bit
    genvar g;
    generate
        for (g = 0; g < `BMU_DATA_W; g++) begin : g_mask
            assign sel_mask[g] = (idx == `BMU_IDX_W'(g));
        end
    endgenerate

    assign bit_val = |(opnd & sel_mask);

    // op decode; non-writing ops keep the byte untouched
    always_comb begin
        res   = opnd;
        wr_en = 1'b0;
        c_out = c_in;
        c_wr  = 1'b0;
        z_out = 1'b0;
        z_wr  = 1'b0;
        case (op)
            BMU_SET: begin
                res = opnd | sel_mask;
                wr_en = 1'b1;
            end
            BMU_CLEAR: begin
                res = opnd & ~sel_mask;
                wr_en = 1'b1;
            end
            BMU_INVERT: begin
                res = opnd ^ sel_mask;
                wr_en = 1'b1;
            end
            BMU_TEST: begin
                z_out = ~bit_val;
                z_wr = 1'b1;
            end
            BMU_CAND: begin
                c_out = c_in & bit_val;
                c_wr = 1'b1;
            end
            BMU_CAND_INV: begin
                c_out = c_in & ~bit_val;
                c_wr = 1'b1;
            end
            BMU_COR: begin
                c_out = c_in | bit_val;
                c_wr = 1'b1;
            end
            BMU_COR_INV: begin
                c_out = c_in | ~bit_val;
                c_wr = 1'b1;
            end
            BMU_CXOR: begin
                c_out = c_in ^ bit_val;
                c_wr = 1'b1;
            end
            BMU_CXOR_INV: begin
                c_out = c_in ^ ~bit_val;
                c_wr = 1'b1;
            end
            BMU_LOAD: begin
                c_out = bit_val;
                c_wr = 1'b1;
            end
            BMU_LOAD_INV: begin
                c_out = ~bit_val;
                c_wr = 1'b1;
            end
            BMU_STORE: begin
                res = c_in ? (opnd | sel_mask) : (opnd & ~sel_mask);
                wr_en = 1'b1;
            end
            BMU_STORE_INV: begin
                res = c_in ? (opnd & ~sel_mask) : (opnd | sel_mask);
                wr_en = 1'b1;
            end
            default: begin
                res = opnd;
            end
        endcase
    end
endmodule // bmu_bitop

// ==== bench/bmu_unit_monitor.sv ====
// Purpose: port checker for the single-bit unit
// Assumes: ce stays high while a memory operation writes back
// Notes:   register-operand results are checked one edge after the request
`timescale 1ns/1ps
`include "bmu_params.svh"
module bmu_unit_monitor
    import bmu_pkg::*;
(
    // clock and control
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   ce,
    // request
    input wire logic                   req,
    input wire logic                   busy,
    input wire bmu_op_t                op,
    input wire logic                   idx_from_reg,
    input wire logic [`BMU_IDX_W-1:0]  idx_imm,
    input wire logic [`BMU_DATA_W-1:0] idx_reg,
    input wire logic                   opnd_is_mem,
    input wire logic [`BMU_DATA_W-1:0] reg_opnd,
    // results
    input wire logic                   reg_we,
    input wire logic [`BMU_DATA_W-1:0] reg_wdata,
    input wire logic                   mem_rd,
    input wire logic                   mem_wr,
    input wire logic                   c_flag,
    input wire logic                   z_flag,
    input wire logic                   done
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic       inv_op; // inverted forms never take the register index
    logic [2:0] sel;    // index the request should use
    logic       bit_v;  // selected operand bit
    logic [7:0] mask;   // one-hot mask of that bit
    logic       go;     // register request taken at this edge
    assign inv_op = op inside {BMU_CAND_INV, BMU_COR_INV, BMU_CXOR_INV, BMU_LOAD_INV,
                               BMU_STORE_INV};
    assign sel    = (idx_from_reg && !inv_op) ? idx_reg[2:0] : idx_imm;
    assign bit_v  = reg_opnd[sel];
    assign mask   = 8'h01 << sel;
    assign go     = req && !busy && ce && !opnd_is_mem;
    // memory request taken, then a running cycle
    sequence s_mem_go;
        (req && !busy && ce && opnd_is_mem) ##1 ce;
    endsequence
    property p_set;
        go && op == BMU_SET |=> reg_we && reg_wdata == ($past(reg_opnd) | $past(mask));
    endproperty
    property p_clear;
        go && op == BMU_CLEAR |=> reg_wdata == ($past(reg_opnd) & ~$past(mask));
    endproperty
    property p_invert;
        go && op == BMU_INVERT |=> reg_wdata == ($past(reg_opnd) ^ $past(mask));
    endproperty
    property p_test;
        go && op == BMU_TEST |=> !reg_we && z_flag == !$past(bit_v);
    endproperty
    property p_cxor;
        go && op == BMU_CXOR |=> c_flag == ($past(c_flag) ^ $past(bit_v));
    endproperty
    property p_load;
        go && op == BMU_LOAD |=> c_flag == $past(bit_v) && !reg_we;
    endproperty
    property p_store_inv;
        go && op == BMU_STORE_INV |=> reg_wdata ==
            (($past(reg_opnd) & ~$past(mask)) | ($past(c_flag) ? 8'h00 : $past(mask)));
    endproperty
    property p_mem_rd;
        s_mem_go |-> mem_rd && busy ##1 !mem_rd;
    endproperty
    property p_mem_done;
        mem_wr && ce |=> done && !mem_wr;
    endproperty
    a_set:       assert property (p_set) else $error("set result wrong");
    a_clear:     assert property (p_clear) else $error("clear result wrong");
    a_invert:    assert property (p_invert) else $error("invert result wrong");
    a_test:      assert property (p_test) else $error("test flag wrong");
    a_cxor:      assert property (p_cxor) else $error("xor carry wrong");
    a_load:      assert property (p_load) else $error("load carry wrong");
    a_store_inv: assert property (p_store_inv) else $error("store result wrong");
    a_mem_rd:    assert property (p_mem_rd) else $error("memory read strobe wrong");
    a_mem_done:  assert property (p_mem_done) else $error("write-back end wrong");
endmodule // bmu_unit_monitor
bind bmu_unit bmu_unit_monitor bmu_unit_monitor_inst (.clk(clk), .rst(rst), .ce(ce),
    .req(req), .busy(busy), .op(op), .idx_from_reg(idx_from_reg), .idx_imm(idx_imm),
    .idx_reg(idx_reg), .opnd_is_mem(opnd_is_mem), .reg_opnd(reg_opnd), .reg_we(reg_we),
    .reg_wdata(reg_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .c_flag(c_flag),
    .z_flag(z_flag), .done(done));

// ==== bench/bit_manipulation_unit_tb_top.sv ====
// Purpose: self-checking bench for the single-bit unit
// Assumes: memory byte held on mem_rdata for the whole operation
// Notes:   expected results queued by the driver, popped on done
`timescale 1ns/1ps
`include "bmu_params.svh"
module bit_manipulation_unit_tb_top
    import bmu_pkg::*;
();
    typedef struct packed {logic we; logic [7:0] b; logic c; logic z;} bmu_exp_t;
    logic        clk, rst, ce, req, idx_from_reg, opnd_is_mem, c_load, c_load_val;
    bmu_op_t     op;
    logic [2:0]  idx_imm;
    logic [7:0]  idx_reg, reg_opnd, mem_rdata, reg_wdata, mem_wdata, wbyte;
    logic        busy, reg_we, mem_rd, mem_wr, c_flag, z_flag, done, wr_seen, mc, mz;
    logic [31:0] seed;
    int          errors, n_tests;
    bmu_exp_t    q[$];      // results still owed by the unit
    bmu_unit bmu_unit_inst (.clk(clk), .rst(rst), .ce(ce), .req(req), .op(op),
        .idx_from_reg(idx_from_reg), .idx_imm(idx_imm), .idx_reg(idx_reg),
        .opnd_is_mem(opnd_is_mem), .reg_opnd(reg_opnd), .busy(busy), .reg_we(reg_we),
        .reg_wdata(reg_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .c_load(c_load), .c_load_val(c_load_val), .c_flag(c_flag),
        .z_flag(z_flag), .done(done));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input bmu_exp_t seen, input bmu_exp_t exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // carry written from outside while idle
    task automatic load_c(input logic v);
        req        = 1'b0;
        c_load     = 1'b1;
        c_load_val = v;
        mc         = v;
        @(posedge clk);
        #1;
        c_load     = 1'b0;
    endtask
    // one request; register ops return at once so the next one runs back to back
    task automatic issue(input bmu_op_t o, input logic mem);
        logic [31:0] r;
        logic [2:0]  i;
        logic        bv;
        bmu_exp_t    e;
        r            = rnd();
        op           = o;
        opnd_is_mem  = mem;
        idx_imm      = r[10:8];
        idx_reg      = r[18:11];
        idx_from_reg = r[19];
        reg_opnd     = mem ? ~r[7:0] : r[7:0];  // unused source shows the inverse
        mem_rdata    = mem ? r[7:0] : ~r[7:0];
        i  = (r[19] && !(o inside {BMU_CAND_INV, BMU_COR_INV, BMU_CXOR_INV, BMU_LOAD_INV,
             BMU_STORE_INV})) ? r[13:11] : r[10:8];
        bv = r[i];
        e  = {1'b0, r[7:0], mc, mz};
        case (o)
            BMU_SET:      e.b[i] = 1'b1;
            BMU_CLEAR:    e.b[i] = 1'b0;
            BMU_INVERT:   e.b[i] = ~bv;
            BMU_TEST:     e.z    = ~bv;
            BMU_CAND:     e.c    = mc & bv;
            BMU_CAND_INV: e.c    = mc & ~bv;
            BMU_COR:      e.c    = mc | bv;
            BMU_COR_INV:  e.c    = mc | ~bv;
            BMU_CXOR:     e.c    = mc ^ bv;
            BMU_CXOR_INV: e.c    = mc ^ ~bv;
            BMU_LOAD:     e.c    = bv;
            BMU_LOAD_INV: e.c    = ~bv;
            BMU_STORE:    e.b[i] = mc;
            default:      e.b[i] = ~mc;
        endcase
        e.we = o inside {BMU_SET, BMU_CLEAR, BMU_INVERT, BMU_STORE, BMU_STORE_INV};
        if (!e.we) e.b = 8'h00;
        mc = e.c;
        mz = e.z;
        q.push_back(e);
        req = 1'b1;
        @(posedge clk);
        #1;
        if (mem) begin
            ce = r[20];  // req stays up while busy and must be ignored
            @(posedge clk);
            #1;
            req = 1'b0;
            ce  = 1'b1;
            for (int k = 0; k < 8 && busy; k++) begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    // compare each completion against the oldest owed result
    always @(negedge clk) begin
        if (mem_wr) begin
            wr_seen = 1'b1;
            wbyte   = mem_wdata;
        end
        if (done) begin
            if (q.size() == 0) check('1, '0);
            else check({reg_we | wr_seen, reg_we ? reg_wdata : (wr_seen ? wbyte : 8'h00),
                        c_flag, z_flag}, q.pop_front());
            wr_seen = 1'b0;
        end
    end
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        seed = 32;
        {rst, ce} = 2'b11;
        {req, idx_from_reg, opnd_is_mem, c_load, c_load_val, mc, mz, wr_seen} = '0;
        {op, idx_imm, idx_reg, reg_opnd, mem_rdata, wbyte} = '0;
        repeat (8) @(posedge clk);
        #1;
        check({reg_we, reg_wdata, c_flag, z_flag}, '0);
        rst = 1'b0;
        for (int n = 0; n < 300; n++) begin
            r = rnd();
            if (r[3:2] == 2'b00) load_c(r[0]);
            issue(bmu_op_t'(4'(n % 14)), r[1]);
        end
        req = 1'b0;
        repeat (6) @(posedge clk);
        check('0, {10'h000, q.size() != 0});
        give_verdict();
    end
endmodule // bit_manipulation_unit_tb_top
